/* src/tcn_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - run bit enables counting
// - source select with sync picks mode
// - internal source counts instruction cycles divided by the prescaler (every one at 1:1)
// - external source counts pin or oscillator edges
// - sync bit synchronises external clock only
// - oscillator enable drives or stops oscillator
// - access bit picks sixteen or eight bit
// - count readable and writable as two bytes
// - special event trigger clears count
// - enabled block forces pins input, reads zero
// - control resets zero; clock status read only
module tcn_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // surrounding chip
  input  wire logic       special_event,
  input  wire logic       system_clock_from_timer_osc,
  input  wire logic [1:0] port_direction,
  output logic      [1:0] pin_is_input,
  output logic      [1:0] pin_read_value,
  output logic            irq,
  // pins: oscillator input, and shared external clock / oscillator output
  input  wire logic       oscillator_input_pin_i,
  input  wire logic       external_clock_pin_i,
  output logic            oscillator_output_pin_o,
  output logic            oscillator_output_pin_oe
);
  tcn_presc_if pif ();

  // register state
  logic [7:0]  control_reg;      // timer_control
  logic [7:0]  control_next;
  logic [15:0] count_reg;        // the 16-bit count
  logic [15:0] count_next;
  logic [7:0]  high_buf_reg;     // high byte buffer for wide access
  logic [7:0]  high_buf_next;
  logic [7:0]  irq_stat_reg;     // sticky event flags
  logic [7:0]  irq_stat_next;
  logic [7:0]  irq_mask_reg;     // enables for the flags
  logic [7:0]  irq_mask_next;
  logic [7:0]  rdata_reg;        // read data, one cycle after strobe
  logic [7:0]  rdata_next;
  // instruction clock phase
  logic [1:0]  phase_reg;
  logic [1:0]  phase_next;
  // pin synchronisers: first stage, second stage, edge history
  logic [1:0]  pin_s1_reg;
  logic [1:0]  pin_s2_reg;
  logic [1:0]  pin_s3_reg;
  logic        ext_pend_reg;     // edge waiting for the instruction cycle
  logic        ext_pend_next;

  // control fields
  logic        run_enable;
  logic        clock_source_select;
  logic        sync_disable;
  logic        oscillator_enable;
  logic [1:0]  prescale_select;
  logic        wide_access_mode;
  // derived events
  logic        instr_tick;       // one reference cycle per instruction
  logic        src_level;        // selected external level, synchronised
  logic        src_last;         // same level one cycle earlier
  logic        ext_edge;         // rising edge of selected source
  logic        ext_tick;         // edge after optional synchronisation
  logic        inc;              // counter advances this cycle
  logic        wr_ctl;
  logic        wr_low;
  logic        wr_high;

  assign run_enable          = control_reg[tcn_pkg::BIT_RUN_ENABLE];
  assign clock_source_select = control_reg[tcn_pkg::BIT_CLK_SOURCE];
  assign sync_disable        = control_reg[tcn_pkg::BIT_SYNC_DISABLE];
  assign oscillator_enable   = control_reg[tcn_pkg::BIT_OSC_ENABLE];
  assign prescale_select     = control_reg[tcn_pkg::BIT_PRESCALE_LO +: 2];
  assign wide_access_mode    = control_reg[tcn_pkg::BIT_WIDE_ACCESS];

  assign wr_ctl  = reg_wr && (reg_addr == tcn_pkg::OFF_CONTROL);
  assign wr_low  = reg_wr && (reg_addr == tcn_pkg::OFF_COUNT_LOW);
  assign wr_high = reg_wr && (reg_addr == tcn_pkg::OFF_COUNT_HI);

  // instruction cycle marker: reference clock divided by four
  assign instr_tick = (phase_reg == tcn_pkg::INSTR_LAST_PH);

  // source level: oscillator input when enabled, else external pin
  always_comb begin
    if (oscillator_enable) begin
      src_level = pin_s2_reg[1];
      src_last  = pin_s3_reg[1];
    end else begin
      src_level = pin_s2_reg[0];
      src_last  = pin_s3_reg[0];
    end
  end
  assign ext_edge = src_level && !src_last;

  // external tick: direct when unsynchronised, else at instruction cycle
  always_comb begin
    ext_pend_next = ext_pend_reg;
    ext_tick      = 1'b0;
    if (!clock_source_select || !run_enable) begin
      // sync bit ignored while the internal clock is used
      ext_pend_next = 1'b0;
    end else if (sync_disable) begin
      ext_tick      = ext_edge;
      ext_pend_next = 1'b0;
    end else if (instr_tick) begin
      ext_tick      = ext_edge || ext_pend_reg;
      ext_pend_next = 1'b0;
    end else begin
      ext_pend_next = ext_pend_reg || ext_edge;
    end
  end

  // prescaler hookup
  always_comb begin
    // source select chooses timer or counter operation
    if (clock_source_select) begin
      pif.in_tick = run_enable && ext_tick;
    end else begin
      pif.in_tick = run_enable && instr_tick;
    end
    pif.sel   = prescale_select;
    pif.clear = wr_ctl || wr_low || wr_high;
  end

  tcn_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pif     (pif.div)
  );

  assign inc = run_enable && pif.out_tick;

  // next register state, register side effects and read mux
  always_comb begin
    control_next  = control_reg;
    count_next    = count_reg;
    high_buf_next = high_buf_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next    = 8'h00;
    phase_next    = 2'(phase_reg + 2'h1);
    // counting
    if (inc) begin
      count_next = 16'(count_reg + 16'h0001);
    end
    // software writes
    if (wr_ctl) begin
      // clock status bit is not writable
      control_next = (reg_wdata & tcn_pkg::CONTROL_WR_MASK);
    end
    if (wr_low) begin
      if (wide_access_mode) begin
        // buffered high byte goes in with the low byte
        count_next = {high_buf_reg, reg_wdata};
      end else begin
        count_next[7:0] = reg_wdata;
      end
    end
    if (wr_high) begin
      if (wide_access_mode) begin
        high_buf_next = reg_wdata;
      end else begin
        count_next[15:8] = reg_wdata;
      end
    end
    if (reg_wr && (reg_addr == tcn_pkg::OFF_IRQ_MASK)) begin
      irq_mask_next = reg_wdata & tcn_pkg::IRQ_IMPL_MASK;
    end
    if (reg_wr && (reg_addr == tcn_pkg::OFF_IRQ_STAT)) begin
      // write one to clear
      irq_stat_next = irq_stat_reg & ~reg_wdata;
    end
    // wrap sets the flag; the set wins over a same-cycle clear
    if (inc && (count_reg == tcn_pkg::COUNT_ALL_ONES)) begin
      irq_stat_next[tcn_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
    end
    // special event trigger has the last word on the count
    if (special_event) begin
      count_next = 16'h0000;
    end
    // reads
    if (reg_rd) begin
      case (reg_addr)
        tcn_pkg::OFF_CONTROL: begin
          rdata_next = control_reg;
          rdata_next[tcn_pkg::BIT_SYSCLK_OSC] =
            system_clock_from_timer_osc;
        end
        tcn_pkg::OFF_COUNT_LOW: begin
          rdata_next = count_reg[7:0];
          if (wide_access_mode) begin
            // capture high byte so both halves match
            high_buf_next = count_reg[15:8];
          end
        end
        tcn_pkg::OFF_COUNT_HI: begin
          if (wide_access_mode) begin
            rdata_next = high_buf_reg;
          end else begin
            rdata_next = count_reg[15:8];
          end
        end
        tcn_pkg::OFF_IRQ_STAT: begin
          rdata_next = irq_stat_reg;
        end
        tcn_pkg::OFF_IRQ_MASK: begin
          rdata_next = irq_mask_reg;
        end
        default: begin
          // unmapped addresses read zero
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control_reg  <= tcn_pkg::CONTROL_RESET;
      count_reg    <= 16'h0000;
      high_buf_reg <= 8'h00;
      irq_stat_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
      rdata_reg    <= 8'h00;
      phase_reg    <= 2'h0;
      ext_pend_reg <= 1'b0;
      pin_s1_reg   <= 2'h0;
      pin_s2_reg   <= 2'h0;
      pin_s3_reg   <= 2'h0;
    end else begin
      control_reg  <= control_next;
      count_reg    <= count_next;
      high_buf_reg <= high_buf_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg    <= rdata_next;
      phase_reg    <= phase_next;
      ext_pend_reg <= ext_pend_next;
      // two-stage synchroniser, then edge history
      pin_s1_reg   <= {oscillator_input_pin_i, external_clock_pin_i};
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(irq_stat_reg & irq_mask_reg);

  // oscillator amplifier: inverts the input, off when disabled
  assign oscillator_output_pin_oe = oscillator_enable;
  assign oscillator_output_pin_o  = oscillator_enable && !pin_s2_reg[1];

  // port override while the block runs
  always_comb begin
    if (run_enable) begin
      pin_is_input   = 2'h3;
      pin_read_value = 2'h0;
    end else begin
      pin_is_input   = port_direction;
      pin_read_value = {pin_s2_reg[1], pin_s2_reg[0]};
    end
  end
endmodule : tcn_timer
`default_nettype wire

/* src/tcn_pkg.sv */
package tcn_pkg;
  // register offsets on the plain register port (byte addresses)
  localparam logic [2:0] OFF_CONTROL   = 3'h0;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h1;
  localparam logic [2:0] OFF_COUNT_HI  = 3'h2;
  localparam logic [2:0] OFF_IRQ_STAT  = 3'h3;
  localparam logic [2:0] OFF_IRQ_MASK  = 3'h4;
  // control register field positions
  localparam int BIT_RUN_ENABLE   = 0;
  localparam int BIT_CLK_SOURCE   = 1;
  localparam int BIT_SYNC_DISABLE = 2;
  localparam int BIT_OSC_ENABLE   = 3;
  localparam int BIT_PRESCALE_LO  = 4;
  localparam int BIT_SYSCLK_OSC   = 6;
  localparam int BIT_WIDE_ACCESS  = 7;
  // writable bits of the control register (clock status is read only)
  localparam logic [7:0] CONTROL_WR_MASK = 8'hBF;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  // interrupt status layout
  localparam int BIT_OVERFLOW_FLAG = 0;
  localparam logic [7:0] IRQ_IMPL_MASK = 8'h01;
  // instruction clock is the reference clock divided by this figure
  localparam int          INSTR_DIV      = 4;
  localparam logic [1:0]  INSTR_LAST_PH  = 2'(INSTR_DIV - 1);
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
endpackage : tcn_pkg

/* src/tcn_presc_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the selected clock tick into the prescaler and its output back
interface tcn_presc_if;
  logic       in_tick;   // one selected input clock edge
  logic       clear;     // restart the division
  logic [1:0] sel;       // prescale code
  logic       out_tick;  // divided tick toward the counter
  modport ctrl (output in_tick, output clear, output sel, input out_tick);
  modport div  (input in_tick, input clear, input sel, output out_tick);
endinterface : tcn_presc_if
`default_nettype wire

/* src/tcn_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
// divides input ticks by 1, 2, 4 or 8
module tcn_prescaler (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  tcn_presc_if.div   pif
);
  logic [2:0] div_cnt_reg;   // ticks seen in the current period
  logic [2:0] div_cnt_next;
  logic [2:0] last_val;      // count value that ends a period

  // next count and output tick
  always_comb begin
    last_val = 3'((4'h1 << pif.sel) - 4'h1);
    div_cnt_next = div_cnt_reg;
    pif.out_tick = 1'b0;
    if (pif.clear) begin
      // a control or count write restarts the division
      div_cnt_next = 3'h0;
    end else if (pif.in_tick) begin
      if (div_cnt_reg == last_val) begin
        pif.out_tick = 1'b1;
        div_cnt_next = 3'h0;
      end else begin
        div_cnt_next = 3'(div_cnt_reg + 3'h1);
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end
endmodule : tcn_prescaler
`default_nettype wire

/* dv/tcn_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the timer ports against a shadow of control and mask
module tcn_timer_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       special_event,
  input wire logic       system_clock_from_timer_osc,
  input wire logic [1:0] port_direction,
  input wire logic [1:0] pin_is_input,
  input wire logic [1:0] pin_read_value,
  input wire logic       irq,
  input wire logic       oscillator_input_pin_i,
  input wire logic       external_clock_pin_i,
  input wire logic       oscillator_output_pin_o,
  input wire logic       oscillator_output_pin_oe
);
  logic [7:0] ctl_reg;   // shadow of writable control bits
  logic       mask_reg;  // shadow of overflow mask
  // shadow follows software writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl_reg  <= 8'h00;
      mask_reg <= 1'b0;
    end else if (reg_wr && reg_addr == tcn_pkg::OFF_CONTROL) begin
      ctl_reg <= reg_wdata & tcn_pkg::CONTROL_WR_MASK;
    end else if (reg_wr && reg_addr == tcn_pkg::OFF_IRQ_MASK) begin
      mask_reg <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  unmapped_read_a: assert property (reg_rd && reg_addr > 3'h4
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  ctl_readback_a: assert property (
    reg_rd && reg_addr == tcn_pkg::OFF_CONTROL
    |=> (reg_rdata & 8'hBF) == ctl_reg) else $error("control readback");
  sysclk_status_a: assert property (
    reg_rd && reg_addr == tcn_pkg::OFF_CONTROL
    |=> reg_rdata[6] == $past(system_clock_from_timer_osc))
    else $error("clock status bit wrong");
  forced_input_a: assert property (ctl_reg[0] |-> pin_is_input == 2'h3)
    else $error("pins not forced to input");
  pins_zero_a: assert property (ctl_reg[0] |-> pin_read_value == 2'h0)
    else $error("pins not read as zero");
  direction_pass_a: assert property (
    !ctl_reg[0] |-> pin_is_input == port_direction)
    else $error("direction not passed through");
  osc_enable_a: assert property (oscillator_output_pin_oe == ctl_reg[3])
    else $error("oscillator drive enable wrong");
  osc_off_a: assert property (!ctl_reg[3] |-> !oscillator_output_pin_o)
    else $error("oscillator output active while off");
  irq_masked_a: assert property (!mask_reg && !$past(mask_reg) |-> !irq)
    else $error("interrupt while masked");
  event_clear_a: assert property (
    special_event && !ctl_reg[0] ##1 !reg_wr ##1 reg_rd
    && reg_addr == tcn_pkg::OFF_COUNT_LOW
    |=> reg_rdata == 8'h00) else $error("count not cleared by event");
endmodule : tcn_timer_checker
bind tcn_timer tcn_timer_checker i_chk (.ref_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .special_event,
  .system_clock_from_timer_osc, .port_direction, .pin_is_input,
  .pin_read_value, .irq, .oscillator_input_pin_i, .external_clock_pin_i,
  .oscillator_output_pin_o, .oscillator_output_pin_oe);
`default_nettype wire

/* dv/tcn_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: external clock pin and low-power crystal, both idle low
module tcn_clk_src (
  output logic ext_pin,  // external clock pin
  output logic osc_pin   // crystal input
);
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // n rising edges on one source, half period in ns, then idle low
  task automatic pulses(input logic use_osc, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      #(half);
      if (use_osc) osc_pin = 1'b1; else ext_pin = 1'b1;
      #(half);
      if (use_osc) osc_pin = 1'b0; else ext_pin = 1'b0;
    end
  endtask : pulses
endmodule : tcn_clk_src
`default_nettype wire

/* dv/sixteen_bit_timer_counter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_counter_tb;
  typedef struct {logic [7:0] ctl; int cyc; logic [7:0] dl;} tcn_row_type;
  logic       ref_clk = 1'b0;  // 100 MHz
  logic       rst_n, reg_wr, reg_rd, special_event, sysclk;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, d0;
  logic [1:0] port_direction, pin_is_input;
  logic [1:0] pin_rv;          // pin read value seen by the port
  logic       irq, ext_pin, osc_pin, osc_oe;
  int         error_cnt = 0;
  int         n_checks  = 0;
  // control, window in cycles, expected low-byte advance
  tcn_row_type rows [6] = '{'{8'h01, 20, 8'h05}, '{8'h11, 40, 8'h05},
    '{8'h21, 80, 8'h05}, '{8'h31, 160, 8'h05}, '{8'h05, 20, 8'h05},
    '{8'h30, 160, 8'h00}};
  always #5 ref_clk = ~ref_clk;
  tcn_timer i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .special_event,
    .system_clock_from_timer_osc(sysclk), .port_direction, .pin_is_input,
    .pin_read_value(pin_rv), .irq, .oscillator_input_pin_i(osc_pin),
    .external_clock_pin_i(ext_pin), .oscillator_output_pin_o(),
    .oscillator_output_pin_oe(osc_oe));
  tcn_clk_src i_src (.ext_pin, .osc_pin);
  // one write cycle on the register port
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // one read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  // read one register and compare
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    chk8("register read", e, d);
  endtask : rdc
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // watchdog far beyond the expected run of about 800 cycles
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, special_event, sysclk} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    port_direction = 2'h1;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(tcn_pkg::OFF_CONTROL, 8'h00);
    chk8("pin direction", 8'h01, {6'h00, pin_is_input});
    chk8("pin read", 8'h00, {6'h00, pin_rv});
    sysclk <= 1'b1;
    wr(tcn_pkg::OFF_CONTROL, 8'hFF);
    rdc(tcn_pkg::OFF_CONTROL, 8'hFF);
    chk8("pin forced input", 8'h03, {6'h00, pin_is_input});
    sysclk <= 1'b0;
    wr(tcn_pkg::OFF_CONTROL, 8'hB0);
    rdc(tcn_pkg::OFF_CONTROL, 8'hB0);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    // advance of the low byte over a fixed window of the internal clock
    foreach (rows[i]) begin
      wr(tcn_pkg::OFF_CONTROL, rows[i].ctl);
      rd(tcn_pkg::OFF_COUNT_LOW, d0);
      repeat (rows[i].cyc - 2) @(posedge ref_clk);
      rd(tcn_pkg::OFF_COUNT_LOW, d);
      chk8("count advance", rows[i].dl, d - d0);
    end
    wr(3'h1, 8'h34);
    wr(3'h2, 8'h12);
    rdc(3'h1, 8'h34);
    rdc(3'h2, 8'h12);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'h55);
    wr(3'h0, 8'h00);
    rdc(3'h2, 8'h12);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'hAB);
    wr(3'h1, 8'hCD);
    rdc(3'h1, 8'hCD);
    rdc(3'h2, 8'hAB);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hFE);
    wr(3'h2, 8'hFF);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'h01);
    repeat (20) @(posedge ref_clk);
    wr(3'h0, 8'h00);
    chk1("irq", 1'b1, irq);
    rdc(3'h3, 8'h01);
    wr(3'h4, 8'h00);
    chk1("irq", 1'b0, irq);
    wr(3'h4, 8'h01);
    chk1("irq", 1'b1, irq);
    wr(3'h3, 8'h01);
    chk1("irq", 1'b0, irq);
    @(posedge ref_clk) special_event <= 1'b1;
    @(posedge ref_clk) special_event <= 1'b0;
    rdc(3'h1, 8'h00);
    rdc(3'h2, 8'h00);
    // external pin, synchronised, unsynchronised, then divided by two
    wr(3'h0, 8'h03);
    i_src.pulses(1'b0, 6, 37);
    repeat (12) @(posedge ref_clk);
    wr(3'h0, 8'h00);
    rdc(3'h1, 8'h06);
    wr(3'h0, 8'h07);
    i_src.pulses(1'b0, 4, 37);
    repeat (12) @(posedge ref_clk);
    wr(3'h0, 8'h13);
    rdc(3'h1, 8'h0A);
    i_src.pulses(1'b0, 4, 37);
    repeat (12) @(posedge ref_clk);
    wr(3'h0, 8'h0B);
    rdc(3'h1, 8'h0C);
    chk1("oscillator enable", 1'b1, osc_oe);
    // crystal counts while the pin toggles unselected
    fork
      i_src.pulses(1'b1, 3, 37);
      i_src.pulses(1'b0, 5, 23);
    join
    repeat (12) @(posedge ref_clk);
    wr(3'h0, 8'h00);
    rdc(3'h1, 8'h0F);
    final_report;
  end
endmodule : sixteen_bit_timer_counter_tb
`default_nettype wire
